/* File: pkg/stm_pkg.sv */
// Package with register map, field positions and mode codes of the timer.
package stm_pkg;

  // Register offsets on the plain register port.
  localparam logic [2:0] STM_OFF_CTRL0    = 3'h0;
  localparam logic [2:0] STM_OFF_CTRL1    = 3'h1;
  localparam logic [2:0] STM_OFF_CNT_LO   = 3'h2;
  localparam logic [2:0] STM_OFF_CNT_HI   = 3'h3;
  localparam logic [2:0] STM_OFF_CMPA_LO  = 3'h4;
  localparam logic [2:0] STM_OFF_CMPA_HI  = 3'h5;
  localparam logic [2:0] STM_OFF_FLAGS    = 3'h6;

  // Field positions in the control registers and the flag register.
  localparam int STM_CTRL0_ON_BIT   = 3;
  localparam int STM_FLAG_A_BIT     = 0;
  localparam int STM_FLAG_P_BIT     = 1;

  // Reset values.
  localparam logic [7:0] STM_CTRL_RESET = 8'h00;
  localparam logic [9:0] STM_CMPA_RESET = 10'h000;
  localparam logic [9:0] STM_CNT_RESET  = 10'h000;
  localparam logic [9:0] STM_CNT_MAX    = 10'h3FF;

  // Operating modes.
  typedef enum logic [1:0] {
    STM_MODE_COMPARE = 2'b00,
    STM_MODE_CAPTURE = 2'b01,
    STM_MODE_PWM     = 2'b10,
    STM_MODE_TIMER   = 2'b11
  } stm_mode_t;

  // Pin function codes.
  typedef enum logic [1:0] {
    STM_PIN_KEEP   = 2'b00,
    STM_PIN_LOW    = 2'b01,
    STM_PIN_HIGH   = 2'b10,
    STM_PIN_TOGGLE = 2'b11
  } stm_pin_fn_t;

  // Second control register layout.
  typedef struct packed {
    stm_mode_t   mode_select;
    stm_pin_fn_t pin_function_select;
    logic        output_initial_level;
    logic        output_invert;
    logic        period_duty_swap;
    logic        clear_source_select;
  } stm_ctrl1_t;

  // Register port request.
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } stm_req_t;

endpackage

/* File: core/stm_timer.sv */
// Standard timer with compare A and compare P, counter and output pin.
`timescale 1ns/1ps
`default_nettype none
module stm_timer
  import stm_pkg::*;
(
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Register port.
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  // Capture input pin.
  input  wire logic       capture_in,
  // Timer output pin.
  output var  logic       timer_output_pin,
  // Event flags as levels for an interrupt controller.
  output var  logic       compare_a_flag,
  output var  logic       compare_p_flag
);

  stm_req_t   req;
  logic [7:0] ctrl0;
  stm_ctrl1_t ctrl1;
  logic [9:0] compare_a_value;
  logic [9:0] count;
  logic       on_q;
  logic       pin_level;
  logic       capture_q;
  logic       capture_edge;
  logic [2:0] compare_p_value;
  logic       counter_on;
  logic       on_rise;
  logic       match_a;
  logic       match_p;
  logic       p_zero;
  logic       a_zero;
  logic       at_max;
  logic       pulse_mode;
  logic       clear_count;
  logic       set_a;
  logic       set_p;
  logic [9:0] period_end;
  logic [9:0] duty_end;
  logic       pwm_active;
  logic       next_pin;
  logic       wr_on_clear;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign counter_on      = ctrl0[STM_CTRL0_ON_BIT];
  assign compare_p_value = ctrl0[2:0];
  assign on_rise         = counter_on & ~on_q;
  assign pulse_mode      = (ctrl1.mode_select == STM_MODE_PWM) &&
                           (ctrl1.pin_function_select == STM_PIN_TOGGLE);

  // Comparators; a nonzero P sets the top three bits of its match count, the low seven bits all ones.
  assign p_zero  = (compare_p_value == 3'h0);
  assign a_zero  = (compare_a_value == STM_CMPA_RESET);
  assign at_max  = (count == STM_CNT_MAX);
  assign match_a = counter_on & ~a_zero & (count == compare_a_value);
  assign match_p = counter_on & (p_zero ? at_max :
                   (count == {compare_p_value, 7'h7F}));

  // PWM period and duty end points, chosen by the swap bit.
  always_comb begin
    if (!ctrl1.period_duty_swap) begin
      period_end = p_zero ? STM_CNT_MAX : {compare_p_value, 7'h7F};
      duty_end   = compare_a_value;
    end else begin
      period_end = compare_a_value;
      duty_end   = p_zero ? STM_CNT_MAX : {compare_p_value, 7'h00};
    end
  end

  // Counter clear source per mode; clear source bit only in compare/timer.
  always_comb begin
    unique case (ctrl1.mode_select)
      STM_MODE_COMPARE, STM_MODE_TIMER: begin
        if (ctrl1.clear_source_select) begin
          clear_count = match_a | (a_zero & at_max);
        end else begin
          clear_count = match_p;
        end
      end
      STM_MODE_CAPTURE: clear_count = match_p;
      STM_MODE_PWM: begin
        // Single pulse never wraps; the A match stops it instead.
        clear_count = pulse_mode ? 1'b0 :
                      (counter_on & (count == period_end));
      end
    endcase
  end

  // Flag set conditions per mode.
  always_comb begin
    set_a = match_a;
    set_p = match_p;
    if ((ctrl1.mode_select == STM_MODE_COMPARE ||
         ctrl1.mode_select == STM_MODE_TIMER) &&
        ctrl1.clear_source_select) begin
      set_p = 1'b0;
    end
    if (pulse_mode) begin
      set_p = 1'b0;
    end
    if (ctrl1.mode_select == STM_MODE_CAPTURE) begin
      set_a = capture_edge;
    end
  end

  // Capture edge detect on the input pin, which is taken as synchronous.
  always_comb begin
    unique case (ctrl1.pin_function_select)
      2'b00:   capture_edge = counter_on & capture_in & ~capture_q;
      2'b01:   capture_edge = counter_on & ~capture_in & capture_q;
      2'b10:   capture_edge = counter_on & (capture_in ^ capture_q);
      2'b11:   capture_edge = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      capture_q <= 1'b0;
      on_q      <= 1'b0;
    end else begin
      capture_q <= capture_in;
      on_q      <= counter_on;
    end
  end

  // Counter: cleared by a rising on bit, held while off.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      count <= STM_CNT_RESET;
    end else if (on_rise) begin
      count <= STM_CNT_RESET;
    end else if (counter_on) begin
      if (clear_count) begin
        count <= STM_CNT_RESET;
      end else begin
        count <= count + 10'h001;
      end
    end
  end

  // A single-pulse A match ends the pulse by dropping the on bit.
  assign wr_on_clear = pulse_mode & match_a;

  // Control registers; a software write of the same cycle loses to the
  // hardware clear of the on bit so a finished pulse cannot re-arm silently.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl0 <= STM_CTRL_RESET;
      ctrl1 <= stm_ctrl1_t'(STM_CTRL_RESET);
    end else begin
      if (req.wr && req.addr == STM_OFF_CTRL0) begin
        ctrl0 <= req.wdata;
      end
      if (wr_on_clear) begin
        ctrl0[STM_CTRL0_ON_BIT] <= 1'b0;
      end
      if (req.wr && req.addr == STM_OFF_CTRL1) begin
        ctrl1 <= stm_ctrl1_t'(req.wdata);
      end
    end
  end

  // Compare A register; capture mode loads it from the counter.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      compare_a_value <= STM_CMPA_RESET;
    end else if (ctrl1.mode_select == STM_MODE_CAPTURE && capture_edge) begin
      compare_a_value <= count;
    end else if (req.wr && req.addr == STM_OFF_CMPA_LO) begin
      compare_a_value[7:0] <= req.wdata;
    end else if (req.wr && req.addr == STM_OFF_CMPA_HI) begin
      compare_a_value[9:8] <= req.wdata[1:0];
    end
  end

  // Sticky flags; write one to clear, a same-cycle set wins.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      compare_a_flag <= 1'b0;
      compare_p_flag <= 1'b0;
    end else begin
      if (set_a) begin
        compare_a_flag <= 1'b1;
      end else if (req.wr && req.addr == STM_OFF_FLAGS &&
                   req.wdata[STM_FLAG_A_BIT]) begin
        compare_a_flag <= 1'b0;
      end
      if (set_p) begin
        compare_p_flag <= 1'b1;
      end else if (req.wr && req.addr == STM_OFF_FLAGS &&
                   req.wdata[STM_FLAG_P_BIT]) begin
        compare_p_flag <= 1'b0;
      end
    end
  end

  // PWM active phase runs from counter zero up to the duty end point.
  assign pwm_active = (duty_end >= period_end) | (count < duty_end);

  // Internal pin level before inversion.
  always_comb begin
    next_pin = pin_level;
    unique case (ctrl1.mode_select)
      STM_MODE_COMPARE: begin
        if (on_rise) begin
          next_pin = ctrl1.output_initial_level;
        end else if (match_a) begin
          unique case (ctrl1.pin_function_select)
            STM_PIN_KEEP:   next_pin = pin_level;
            STM_PIN_LOW:    next_pin = 1'b0;
            STM_PIN_HIGH:   next_pin = 1'b1;
            STM_PIN_TOGGLE: next_pin = ~pin_level;
          endcase
        end
      end
      STM_MODE_PWM: begin
        unique case (ctrl1.pin_function_select)
          STM_PIN_KEEP: next_pin = ~ctrl1.output_initial_level;
          STM_PIN_LOW:  next_pin = ctrl1.output_initial_level;
          STM_PIN_HIGH: begin
            next_pin = (counter_on & pwm_active) ?
                       ctrl1.output_initial_level :
                       ~ctrl1.output_initial_level;
          end
          STM_PIN_TOGGLE: begin
            if (on_rise) begin
              next_pin = ctrl1.output_initial_level;
            end else if (!counter_on || match_a) begin
              next_pin = ~ctrl1.output_initial_level;
            end
          end
        endcase
      end
      STM_MODE_CAPTURE: next_pin = pin_level;
      STM_MODE_TIMER:   next_pin = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pin_level        <= 1'b0;
      timer_output_pin <= 1'b0;
    end else begin
      pin_level        <= next_pin;
      // Timer mode leaves the pin unused, so it parks low.
      timer_output_pin <= (ctrl1.mode_select == STM_MODE_TIMER) ? 1'b0 :
                          next_pin ^ ctrl1.output_invert;
    end
  end

  // Read data, one cycle after the read strobe.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        STM_OFF_CTRL0:   reg_rdata <= ctrl0;
        STM_OFF_CTRL1:   reg_rdata <= ctrl1;
        STM_OFF_CNT_LO:  reg_rdata <= count[7:0];
        STM_OFF_CNT_HI:  reg_rdata <= {6'h00, count[9:8]};
        STM_OFF_CMPA_LO: reg_rdata <= compare_a_value[7:0];
        STM_OFF_CMPA_HI: reg_rdata <= {6'h00, compare_a_value[9:8]};
        STM_OFF_FLAGS:   reg_rdata <= {6'h00, compare_p_flag, compare_a_flag};
        default:         reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Checks.
  chk_mode_reach: cover property (@(posedge core_clk) disable iff (!reset_n)
    ctrl1.mode_select == STM_MODE_COMPARE && match_a);
  chk_flag_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
    compare_a_flag && !(req.wr && req.addr == STM_OFF_FLAGS) |=>
    compare_a_flag) else $error("A flag dropped without clear");
  chk_no_p_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
    ctrl1.mode_select == STM_MODE_COMPARE && ctrl1.clear_source_select
    && !compare_p_flag |=> !compare_p_flag)
    else $error("P flag set with clear source A");
  chk_on_rise_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    on_rise |=> count == STM_CNT_RESET)
    else $error("Counter not cleared on start");
  chk_off_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    !counter_on && !$past(counter_on) |-> $stable(count))
    else $error("Counter moved while off");
  chk_init_level: assert property (@(posedge core_clk) disable iff (!reset_n)
    ctrl1.mode_select == STM_MODE_COMPARE && on_rise |=>
    pin_level == $past(ctrl1.output_initial_level))
    else $error("Initial level not loaded");
  chk_p_no_pin: assert property (@(posedge core_clk) disable iff (!reset_n)
    ctrl1.mode_select == STM_MODE_COMPARE && !match_a && !on_rise |=>
    $stable(pin_level)) else $error("Pin moved without A match");
  chk_a_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    ctrl1.mode_select == STM_MODE_COMPARE && ctrl1.clear_source_select &&
    match_a && !on_rise |=> count == STM_CNT_RESET)
    else $error("A match did not clear counter");
  // A zero compare value must never raise the A flag in compare mode.
  chk_a_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    a_zero && ctrl1.mode_select == STM_MODE_COMPARE |=>
    !$rose(compare_a_flag)) else $error("A flag with zero value");
  chk_toggle: assert property (@(posedge core_clk) disable iff (!reset_n)
    ctrl1.mode_select == STM_MODE_COMPARE && match_a && !on_rise &&
    ctrl1.pin_function_select == STM_PIN_TOGGLE |=>
    pin_level != $past(pin_level)) else $error("No toggle");
  chk_invert: assert property (@(posedge core_clk) disable iff (!reset_n)
    ctrl1.mode_select != STM_MODE_TIMER && $stable(ctrl1) |=>
    timer_output_pin == (pin_level ^ $past(ctrl1.output_invert)))
    else $error("Pin polarity wrong");
  chk_hi_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    $past(req.rd) && $past(req.addr) == STM_OFF_CNT_HI |->
    reg_rdata[7:2] == 6'h00) else $error("High bits not zero");
  chk_cov_p: cover property (@(posedge core_clk) disable iff (!reset_n)
    set_p && ctrl1.mode_select == STM_MODE_COMPARE);
  chk_cov_pwm: cover property (@(posedge core_clk) disable iff (!reset_n)
    ctrl1.mode_select == STM_MODE_PWM && clear_count);
  chk_cov_cap: cover property (@(posedge core_clk) disable iff (!reset_n)
    ctrl1.mode_select == STM_MODE_CAPTURE && capture_edge);

endmodule
`default_nettype wire

/* File: testbench/stm_timer_tb.sv */
// Self-checking testbench for the standard timer block.
`timescale 1ns/1ps
`default_nettype none
module stm_timer_tb
  import stm_pkg::*;
();
  logic       core_clk;
  logic       reset_n;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       capture_in;
  logic       timer_output_pin;
  logic       compare_a_flag;
  logic       compare_p_flag;
  logic       rd_seen;
  logic [7:0] exp_q[$];
  int         mismatches;
  int         n_compared;

  // Device under test.
  stm_timer dut_u (
    .core_clk         (core_clk),
    .reset_n          (reset_n),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .capture_in       (capture_in),
    .timer_output_pin (timer_output_pin),
    .compare_a_flag   (compare_a_flag),
    .compare_p_flag   (compare_p_flag)
  );

  // Free-running 100 MHz clock.
  always #5 core_clk = ~core_clk;

  task automatic final_report;
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    n_compared++;
    if (seen !== expv) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  always @(posedge core_clk) rd_seen <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_seen && exp_q.size() > 0) check(reg_rdata, exp_q.pop_front());
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Every access leaves an idle edge so no strobe is driven twice at once.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] expv);
    exp_q.push_back(expv);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd_get(input logic [2:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
    @(posedge core_clk);
  endtask

  task automatic set_a(input logic [9:0] v);
    wr(STM_OFF_CMPA_LO, v[7:0]);
    wr(STM_OFF_CMPA_HI, {6'h00, v[9:8]});
  endtask

  // Pin is sampled mid-cycle so that the edge's updates have landed.
  task automatic chk_pin(input logic e);
    @(negedge core_clk);
    check({7'h00, timer_output_pin}, {7'h00, e});
    @(posedge core_clk);
  endtask

  // A flag that never comes counts as a mismatch; the run goes on.
  task automatic wait_flag(input logic pf);
    int k;
    k = 0;
    while ((pf ? compare_p_flag : compare_a_flag) !== 1'b1 && k < 1200) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 1200) check(8'h00, 8'h01);
  endtask

  // Watchdog sized well above the roughly five and a half thousand cycles of the tests.
  initial begin
    #300000;
    mismatches++;
    final_report;
  end

  // Main sequence.
  initial begin
    logic [9:0] av;
    logic [7:0] v;
    logic       e;
    int         k;
    core_clk = 1'b0;
    reset_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    capture_in = 1'b0;
    mismatches = 0;
    n_compared = 0;
    void'($urandom(89396));
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    // Reset values, with the unmapped slot reading zero as well.
    for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
    av = 10'($urandom);
    v = 8'($urandom);
    wr(STM_OFF_CMPA_LO, av[7:0]);
    wr(STM_OFF_CMPA_HI, {v[7:2], av[9:8]});
    wr(STM_OFF_CNT_LO, 8'hA5);
    wr(STM_OFF_CNT_HI, 8'hFF);
    wr(3'h7, 8'h5A);
    rd(STM_OFF_CMPA_LO, av[7:0]);
    rd(STM_OFF_CMPA_HI, {6'h00, av[9:8]});
    rd(STM_OFF_CNT_LO, 8'h00);
    rd(STM_OFF_CNT_HI, 8'h00);
    rd(3'h7, 8'h00);
    // Compare mode, clear on A: every pin function, level and inversion.
    for (int f = 0; f < 4; f++) begin
      for (int i = 0; i < 2; i++) begin
        for (int p = 0; p < 2; p++) begin
          set_a(10'(12 + $urandom_range(40)));
          wr(STM_OFF_CTRL1, {2'b00, 2'(f), 1'(i), 1'(p), 2'b01});
          wr(STM_OFF_CTRL0, 8'h08);
          wait_cyc(2);
          chk_pin(1'(i) ^ 1'(p));
          wait_flag(1'b0);
          e = (f == 0) ? 1'(i) : (f == 1) ? 1'b0 : (f == 2) ? 1'b1 : ~1'(i);
          chk_pin(e ^ 1'(p));
          check({7'h00, compare_p_flag}, 8'h00);
          if (f == 3) begin
            wr(STM_OFF_FLAGS, 8'h03);
            wait_flag(1'b0);
            chk_pin(1'(i) ^ 1'(p));
          end
          rd(STM_OFF_FLAGS, 8'h01);
          wr(STM_OFF_CTRL0, 8'h00);
          wr(STM_OFF_FLAGS, 8'h03);
          rd(STM_OFF_FLAGS, 8'h00);
        end
      end
    end
    // Clear on P with P = 1: both flags, counter never passes 0FF.
    set_a(10'h010);
    wr(STM_OFF_CTRL1, 8'h00);
    wr(STM_OFF_CTRL0, 8'h09);
    wait_flag(1'b1);
    rd(STM_OFF_FLAGS, 8'h03);
    wait_cyc(300);
    rd(STM_OFF_CNT_HI, 8'h00);
    wr(STM_OFF_CTRL0, 8'h00);
    wr(STM_OFF_FLAGS, 8'h03);
    // Compare A of zero: the counter wraps and raises no flag.
    set_a(10'h000);
    wr(STM_OFF_CTRL1, 8'h01);
    wr(STM_OFF_CTRL0, 8'h08);
    wait_cyc(1400);
    rd(STM_OFF_FLAGS, 8'h00);
    // Stopping keeps the count; starting again clears it.
    wr(STM_OFF_CTRL0, 8'h00);
    rd_get(STM_OFF_CNT_LO, v);
    wait_cyc(20);
    rd(STM_OFF_CNT_LO, v);
    wr(STM_OFF_CTRL0, 8'h08);
    rd(STM_OFF_CNT_HI, 8'h00);
    // Timer mode ignores level and inversion; the pin is held low.
    wr(STM_OFF_CTRL0, 8'h00);
    wr(STM_OFF_CTRL1, 8'hEC);
    wr(STM_OFF_CTRL0, 8'h08);
    wait_cyc(3);
    chk_pin(1'b0);
    // PWM forced inactive and active levels under polarity and inversion.
    for (int f = 0; f < 2; f++) begin
      for (int i = 0; i < 2; i++) begin
        for (int p = 0; p < 2; p++) begin
          wr(STM_OFF_CTRL0, 8'h00);
          wr(STM_OFF_CTRL1, {2'b10, 2'(f), 1'(i), 1'(p), 2'b00});
          wr(STM_OFF_CTRL0, 8'h09);
          wait_cyc(2);
          chk_pin((f == 1 ? 1'(i) : ~1'(i)) ^ 1'(p));
        end
      end
    end
    // Duty 3FF against period end 0FF is always active; swapped it is not.
    set_a(10'h3FF);
    for (int s = 0; s < 2; s++) begin
      wr(STM_OFF_CTRL0, 8'h00);
      wr(STM_OFF_CTRL1, {2'b10, 2'b10, 1'b1, 1'b0, 1'(s), 1'b1});
      wr(STM_OFF_CTRL0, 8'h09);
      wait_cyc(3);
      k = 0;
      repeat (1100) begin
        @(negedge core_clk);
        if (timer_output_pin === 1'b1) k++;
      end
      @(posedge core_clk);
      check(8'(k == 1100), 8'(s == 0));
    end
    // Single pulse: leading edge on start, trailing edge on an A match.
    wr(STM_OFF_CTRL0, 8'h00);
    wr(STM_OFF_FLAGS, 8'h03);
    set_a(10'd40);
    wr(STM_OFF_CTRL1, 8'hB8);
    wr(STM_OFF_CTRL0, 8'h08);
    wait_cyc(2);
    chk_pin(1'b1);
    wait_flag(1'b0);
    wait_cyc(1);
    chk_pin(1'b0);
    rd(STM_OFF_CTRL0, 8'h00);
    // Capture on a rising edge of the input raises the A flag.
    wr(STM_OFF_FLAGS, 8'h03);
    wr(STM_OFF_CTRL1, 8'h40);
    wr(STM_OFF_CTRL0, 8'h08);
    wait_cyc(20);
    capture_in <= 1'b1;
    wait_cyc(5);
    rd(STM_OFF_FLAGS, 8'h01);
    wait_cyc(4);
    final_report;
  end
endmodule
`default_nettype wire
